//--- common/csh_pkg.sv
// Purpose: Shared constants for the chroma saturation and hue stage
// Assumes: APB with 32-bit data; each register takes one aligned word
// Notes: Reset values and offsets are used by the top and the bench
package csh_pkg;

  // Data widths
  localparam int CHROMA_W = 8;
  localparam int GAIN_W = 9;
  localparam int HUE_W = 8;
  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] MISC_CONTROL_OFS = 12'h02c;
  localparam logic [11:0] U_GAIN_LOW_BYTE_OFS = 12'h034;
  localparam logic [11:0] V_GAIN_LOW_BYTE_OFS = 12'h038;
  localparam logic [11:0] HUE_PHASE_OFFSET_OFS = 12'h03c;
  localparam logic [11:0] DECODE_MODE_OFS = 12'h0f0;
  localparam logic [11:0] CLIP_STATUS_OFS = 12'h0f4;
  localparam logic [11:0] GAIN_VIEW_OFS = 12'h0f8;

  // Reset values
  localparam logic [7:0] MISC_CONTROL_RST = 8'h20;
  localparam logic [7:0] U_GAIN_LOW_BYTE_RST = 8'hfe;
  localparam logic [7:0] V_GAIN_LOW_BYTE_RST = 8'hb4;
  localparam logic [7:0] HUE_PHASE_OFFSET_RST = 8'h00;

  // Field positions in the miscellaneous control register
  localparam int U_GAIN_TOP_BIT_POS = 1;
  localparam int V_GAIN_TOP_BIT_POS = 0;

  // Field positions in the clip status and gain view registers
  localparam int U_CLIP_POS = 0;
  localparam int V_CLIP_POS = 1;
  localparam int V_VIEW_LSB = 16;

  // Unity gain codes of the two colour-difference paths
  localparam int U_UNITY = 254;
  localparam int V_UNITY = 180;

  // Legal chroma output range
  localparam int CHROMA_MIN = -128;
  localparam int CHROMA_MAX = 127;

  // Log2 of hue steps per full turn of subcarrier phase
  localparam int HUE_TURN_W = 9;

  // Decoding standards
  typedef enum logic [1:0] {
    CSH_STD_NTSC = 2'h0,
    CSH_STD_PAL = 2'h1,
    CSH_STD_SECAM = 2'h2,
    CSH_STD_DIGITAL = 2'h3
  } csh_std_t;

endpackage

//--- rtl/csh_gain_mult.sv
// Purpose: Scales one colour-difference sample by gain over unity code
// Assumes: Signed sample, unsigned gain code, combinational use
// Notes: Quotient truncates toward zero, then clamps to the legal range
`timescale 1ns/1ps
module csh_gain_mult #(
  parameter int UNITY = 254
) (
  // Sample and gain
  input wire logic signed [csh_pkg::CHROMA_W-1:0] sample,
  input wire logic [csh_pkg::GAIN_W-1:0] gain,
  // Result
  output logic signed [csh_pkg::CHROMA_W-1:0] result,
  output logic clipped
);
  import csh_pkg::*;

  localparam int PROD_W = CHROMA_W + GAIN_W + 1;
  localparam logic signed [PROD_W-1:0] UNITY_S = PROD_W'(UNITY);
  localparam logic signed [PROD_W-1:0] MIN_S = PROD_W'(CHROMA_MIN);
  localparam logic signed [PROD_W-1:0] MAX_S = PROD_W'(CHROMA_MAX);

  if (UNITY < 1 || UNITY > 511) begin : g_chk
    $error("csh_gain_mult: UNITY out of range");
  end

  wire logic signed [PROD_W-1:0] product;
  wire logic signed [PROD_W-1:0] quotient;

  // Gain code over unity code; a wide product keeps the top code exact
  assign product = PROD_W'(sample) * $signed({1'b0, gain});
  assign quotient = product / UNITY_S;
  // Clamp rather than wrap, a wrapped colour is far worse than a flat one
  assign clipped = (quotient > MAX_S) || (quotient < MIN_S);
  assign result = (quotient > MAX_S) ? CHROMA_W'(CHROMA_MAX) :
                  (quotient < MIN_S) ? CHROMA_W'(CHROMA_MIN) :
                  quotient[CHROMA_W-1:0];

endmodule // csh_gain_mult

//--- rtl/csh_hue_phase.sv
// Purpose: Adds the signed hue offset to the demodulating subcarrier phase
// Assumes: Phase word spans one full turn; wraps modulo a turn
// Notes: One hue step is one part in 512 of a turn
`timescale 1ns/1ps
module csh_hue_phase #(
  parameter int PHASE_W = 12
) (
  // Phase in and hue
  input wire logic [PHASE_W-1:0] phase_in,
  input wire logic [csh_pkg::HUE_W-1:0] hue,
  input wire logic hue_enable,
  // Adjusted phase
  output logic [PHASE_W-1:0] phase_out
);
  import csh_pkg::*;

  if (PHASE_W < HUE_TURN_W) begin : g_chk
    $error("csh_hue_phase: PHASE_W too narrow for hue steps");
  end

  wire logic [PHASE_W-1:0] hue_ext;
  wire logic [PHASE_W-1:0] hue_step;

  // Sign extend, then scale so that 0x80 is a quarter turn back
  assign hue_ext = PHASE_W'($signed(hue));
  assign hue_step = hue_ext << (PHASE_W - HUE_TURN_W);
  // Offset only applies while decoding NTSC
  assign phase_out = hue_enable ? phase_in + hue_step : phase_in;

endmodule // csh_hue_phase

//--- rtl/csh_chroma_adjust.sv
// Purpose: Chroma saturation gains and hue phase offset, APB registers
// Assumes: One clock pclk at 40 MHz; stream inputs on the same clock
// Notes: Two-cycle pipeline; APB answers one cycle into the access phase
//
// Behaviour
// RQ1 - U gain: top bit plus low byte, 0xFE
// RQ2 - U output equals U times gain over 254
// RQ3 - V gain: top bit plus low byte, 0xB4
// RQ4 - V output equals V times gain over 180
// RQ5 - Software keeps U/V gain ratio at reset ratio
// RQ6 - Software preserves other control bits on update
// RQ7 - Signed hue added to subcarrier phase, 0.7 degree
// RQ8 - Hue resets to zero, phase unchanged
// RQ9 - 0x80 is minus 90, 0x7F plus 89.3
// RQ10 - Hue applies only for NTSC decoding
// RQ11 - Gain products clamp to legal chroma range
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module csh_chroma_adjust #(
  parameter int PHASE_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csh_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chroma stream in
  input wire logic in_valid,
  input wire logic [csh_pkg::CHROMA_W-1:0] in_u,
  input wire logic [csh_pkg::CHROMA_W-1:0] in_v,
  input wire logic [PHASE_W-1:0] in_phase,
  // Chroma stream out
  output logic out_valid,
  output logic [csh_pkg::CHROMA_W-1:0] out_u,
  output logic [csh_pkg::CHROMA_W-1:0] out_v,
  output logic [PHASE_W-1:0] out_phase
);
  import csh_pkg::*;

  if (PHASE_W < HUE_TURN_W || PHASE_W > 32) begin : g_chk
    $error("csh_chroma_adjust: PHASE_W must lie in 9..32");
  end

  // Register state
  logic [7:0] misc_control_reg;
  logic [7:0] u_gain_low_byte_reg;
  logic [7:0] v_gain_low_byte_reg;
  logic [7:0] hue_phase_offset_reg;
  csh_std_t decode_mode_reg;
  logic [1:0] clip_status_reg;
  logic [1:0] clip_status_next;

  // APB answer state
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  // Pipeline stage one
  logic s1_valid_reg;
  logic [CHROMA_W-1:0] s1_u_reg;
  logic [CHROMA_W-1:0] s1_v_reg;
  logic [PHASE_W-1:0] s1_phase_reg;

  // Pipeline stage two, the outputs
  logic out_valid_reg;
  logic [CHROMA_W-1:0] out_u_reg;
  logic [CHROMA_W-1:0] out_v_reg;
  logic [PHASE_W-1:0] out_phase_reg;

  // Bus decode
  wire logic access;
  wire logic commit;
  wire logic wr_commit;
  wire logic lane0;
  wire logic [7:0] wbyte;
  wire logic hit_misc;
  wire logic hit_u;
  wire logic hit_v;
  wire logic hit_hue;
  wire logic hit_mode;
  wire logic hit_status;
  wire logic hit_view;
  wire logic hit_any;
  wire logic [31:0] rd_value;

  // Datapath wires
  wire logic [GAIN_W-1:0] u_chroma_gain;
  wire logic [GAIN_W-1:0] v_chroma_gain;
  wire logic hue_enable;
  wire logic [CHROMA_W-1:0] u_scaled;
  wire logic [CHROMA_W-1:0] v_scaled;
  wire logic u_clip;
  wire logic v_clip;
  wire logic [PHASE_W-1:0] phase_adj;

  // Access phase, then the answer cycle commits the transfer
  assign access = psel && penable;
  assign commit = access && pready_reg;
  assign wr_commit = commit && pwrite && lane0;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];

  // Address decode; the low two bits must be zero
  assign hit_misc = (paddr == MISC_CONTROL_OFS);
  assign hit_u = (paddr == U_GAIN_LOW_BYTE_OFS);
  assign hit_v = (paddr == V_GAIN_LOW_BYTE_OFS);
  assign hit_hue = (paddr == HUE_PHASE_OFFSET_OFS);
  assign hit_mode = (paddr == DECODE_MODE_OFS);
  assign hit_status = (paddr == CLIP_STATUS_OFS);
  assign hit_view = (paddr == GAIN_VIEW_OFS);
  assign hit_any = hit_misc || hit_u || hit_v || hit_hue ||
                   hit_mode || hit_status || hit_view;

  // Read selection; bits above each field read zero
  assign rd_value =
    hit_misc ? {24'h000000, misc_control_reg} :
    hit_u ? {24'h000000, u_gain_low_byte_reg} :
    hit_v ? {24'h000000, v_gain_low_byte_reg} :
    hit_hue ? {24'h000000, hue_phase_offset_reg} :
    hit_mode ? {30'h00000000, decode_mode_reg} :
    hit_status ? {30'h00000000, clip_status_reg} :
    hit_view ? {7'h00, v_chroma_gain, 7'h00, u_chroma_gain} :
    32'h00000000;

  // Nine-bit gains: top bit from control, low byte from its register
  assign u_chroma_gain = {misc_control_reg[U_GAIN_TOP_BIT_POS],
                          u_gain_low_byte_reg}; // [RQ1]
  assign v_chroma_gain = {misc_control_reg[V_GAIN_TOP_BIT_POS],
                          v_gain_low_byte_reg}; // [RQ3]

  // Hue is ignored for PAL, SECAM and digital input
  assign hue_enable = (decode_mode_reg == CSH_STD_NTSC); // [RQ10]

  // U path, unity at code 254
  csh_gain_mult #(
    .UNITY(U_UNITY)
  ) u_gain_mult (
    .sample(s1_u_reg),
    .gain(u_chroma_gain),
    .result(u_scaled),
    .clipped(u_clip)
  ); // [RQ2] [RQ11]

  // V path, unity at code 180
  csh_gain_mult #(
    .UNITY(V_UNITY)
  ) v_gain_mult (
    .sample(s1_v_reg),
    .gain(v_chroma_gain),
    .result(v_scaled),
    .clipped(v_clip)
  ); // [RQ4] [RQ11]

  // Subcarrier phase offset; 0x80 is a quarter turn back
  csh_hue_phase #(
    .PHASE_W(PHASE_W)
  ) hue_phase (
    .phase_in(s1_phase_reg),
    .hue(hue_phase_offset_reg),
    .hue_enable(hue_enable),
    .phase_out(phase_adj)
  ); // [RQ7] [RQ9]

  // Sticky clip flags; a new clip beats a write-one clear
  always_comb begin
    clip_status_next = clip_status_reg;
    if (wr_commit && hit_status) begin
      clip_status_next = clip_status_reg & ~wbyte[1:0];
    end
    if (s1_valid_reg) begin
      clip_status_next[U_CLIP_POS] = clip_status_next[U_CLIP_POS] | u_clip;
      clip_status_next[V_CLIP_POS] = clip_status_next[V_CLIP_POS] | v_clip;
    end
  end

  // APB answer: one wait state, so every output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !hit_any;
      prdata_reg <= (access && !pready_reg && !pwrite && hit_any) ? rd_value : 32'h00000000;
    end
  end

  // Control register writes; the whole control byte is stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_control_reg <= MISC_CONTROL_RST;
      u_gain_low_byte_reg <= U_GAIN_LOW_BYTE_RST; // [RQ1]
      v_gain_low_byte_reg <= V_GAIN_LOW_BYTE_RST; // [RQ3]
      hue_phase_offset_reg <= HUE_PHASE_OFFSET_RST; // [RQ8]
      decode_mode_reg <= CSH_STD_NTSC;
    end else if (wr_commit) begin
      if (hit_misc) begin
        misc_control_reg <= wbyte; // [RQ6]
      end
      if (hit_u) begin
        u_gain_low_byte_reg <= wbyte;
      end
      if (hit_v) begin
        v_gain_low_byte_reg <= wbyte;
      end
      if (hit_hue) begin
        hue_phase_offset_reg <= wbyte;
      end
      if (hit_mode) begin
        decode_mode_reg <= csh_std_t'(wbyte[1:0]);
      end
    end
  end

  // Clip flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clip_status_reg <= 2'h0;
    end else begin
      clip_status_reg <= clip_status_next;
    end
  end

  // Stage one captures the sample; data held when idle saves toggling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid_reg <= 1'b0;
      s1_u_reg <= '0;
      s1_v_reg <= '0;
      s1_phase_reg <= '0;
    end else begin
      s1_valid_reg <= in_valid;
      if (in_valid) begin
        s1_u_reg <= in_u;
        s1_v_reg <= in_v;
        s1_phase_reg <= in_phase;
      end
    end
  end

  // Stage two registers the scaled samples and adjusted phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_reg <= 1'b0;
      out_u_reg <= '0;
      out_v_reg <= '0;
      out_phase_reg <= '0;
    end else begin
      out_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) begin
        out_u_reg <= u_scaled; // [RQ2]
        out_v_reg <= v_scaled; // [RQ4]
        out_phase_reg <= phase_adj; // [RQ7]
      end
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign out_valid = out_valid_reg;
  assign out_u = out_u_reg;
  assign out_v = out_v_reg;
  assign out_phase = out_phase_reg;

endmodule // csh_chroma_adjust

//--- dv/csh_chroma_adjust_props.sv
// Purpose: Port checks of the chroma stage
// Assumes: Hue and mode shadowed from APB writes
// Notes: Bench keeps writes apart from samples
`timescale 1ns/1ps
module csh_chroma_adjust_props #(
  parameter int PHASE_W = 12
) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csh_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Stream
  input wire logic in_valid,
  input wire logic [PHASE_W-1:0] in_phase,
  input wire logic out_valid,
  input wire logic [csh_pkg::CHROMA_W-1:0] out_u,
  input wire logic [csh_pkg::CHROMA_W-1:0] out_v,
  input wire logic [PHASE_W-1:0] out_phase
);
  import csh_pkg::*;
  logic [7:0] hue_reg;
  logic [1:0] mode_reg;
  logic [PHASE_W-1:0] hue_sh;
  wire wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  // Shadow only committed writes, refused ones never land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hue_reg <= 8'h00;
      mode_reg <= 2'h0;
    end else if (wr_ok) begin
      if (paddr == HUE_PHASE_OFFSET_OFS) hue_reg <= pwdata[7:0];
      if (paddr == DECODE_MODE_OFS) mode_reg <= pwdata[1:0];
    end
  end
  // Hue step is eight phase units at this width
  assign hue_sh = (mode_reg == 2'h0) ? ({{(PHASE_W-8){hue_reg[7]}}, hue_reg} << (PHASE_W-9)) : '0;
  chk_out_latency: assert property (@(posedge pclk) disable iff (!presetn) in_valid |-> ##2 out_valid)
    else $error("out_valid missing after sample");
  chk_out_cause: assert property (@(posedge pclk) disable iff (!presetn) out_valid |-> $past(in_valid, 2))
    else $error("out_valid without sample");
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_wait: assert property (@(posedge pclk) disable iff (!presetn) psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn) pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr outside answer");
  chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn) !pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  chk_hue_phase: assert property (@(posedge pclk) disable iff (!presetn)
    out_valid |-> out_phase == $past(in_phase, 2) + $past(hue_sh, 1))
    else $error("phase offset wrong");
  chk_out_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !out_valid |-> $stable(out_u) && $stable(out_v) && $stable(out_phase))
    else $error("outputs moved without sample");
endmodule // csh_chroma_adjust_props

bind csh_chroma_adjust csh_chroma_adjust_props #(.PHASE_W(PHASE_W)) u_csh_chroma_adjust_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_phase(in_phase), .out_valid(out_valid), .out_u(out_u), .out_v(out_v),
  .out_phase(out_phase));

//--- dv/csh_chroma_adjust_tb_top.sv
// Purpose: Directed bench of the chroma stage
// Assumes: APB answer and stream latency per note
// Notes: Expected values from gain and hue math
`timescale 1ns/1ps
module csh_chroma_adjust_tb_top;
  import csh_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_valid = 1'b0;
  logic [11:0] paddr = '0, in_phase = '0, out_phase;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] in_u = '0, in_v = '0, out_u, out_v;
  logic pready, pslverr, out_valid, er;
  int failures = 0;
  int samples_checked = 0;
  always #12.5 pclk = ~pclk;
  csh_chroma_adjust #(.PHASE_W(12)) u_csh_chroma_adjust (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_u(in_u), .in_v(in_v), .in_phase(in_phase),
    .out_valid(out_valid), .out_u(out_u), .out_v(out_v), .out_phase(out_phase));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      failures++;
      $display("BAD %0t apb answer timed out", $time);
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, 4'hf);
    cmp(rd, exp, what);
  endtask
  // One sample in, wait for its result
  task automatic smp(input logic [7:0] u, input logic [7:0] v, input logic [11:0] ph);
    int n;
    @(posedge pclk);
    in_valid <= 1'b1;
    in_u <= u;
    in_v <= v;
    in_phase <= ph;
    @(posedge pclk);
    in_valid <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge pclk);
      #1;
      if (out_valid === 1'b1) break;
    end
    if (n == 4) begin
      failures++;
      $display("BAD %0t sample result timed out", $time);
      complete_run();
    end
  endtask
  function automatic logic [31:0] eg(input logic signed [7:0] s, input int g, input int unity);
    int q;
    q = int'(s) * g / unity;
    if (q > 127) q = 127;
    if (q < -128) q = -128;
    return {24'h0, q[7:0]};
  endfunction
  task automatic t_reset();
    rdc(U_GAIN_LOW_BYTE_OFS, 32'h0000_00fe, "u low");
    rdc(V_GAIN_LOW_BYTE_OFS, 32'h0000_00b4, "v low");
    rdc(HUE_PHASE_OFFSET_OFS, 32'h0, "hue");
    smp(8'd10, 8'hf6, 12'h123);
    cmp({20'h0, out_phase}, 32'h123, "phase");
    cmp({24'h0, out_u}, 32'h0a, "u unity");
    cmp({24'h0, out_v}, 32'hf6, "v unity");
    $display("reset test done");
  endtask
  task automatic t_err();
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    cmp({31'h0, er}, 32'h1, "unmapped err");
    cmp(rd, 32'h0, "unmapped data");
    apb(1'b1, U_GAIN_LOW_BYTE_OFS, 32'h11, 4'h0);
    rdc(U_GAIN_LOW_BYTE_OFS, 32'h0000_00fe, "strobe off");
    $display("error test done");
  endtask
  task automatic t_gain();
    logic [7:0] su [6] = '{8'd100, 8'd50, 8'd127, 8'h80, 8'h9c, 8'h9c};
    logic [8:0] gu [6] = '{9'd254, 9'h1ff, 9'h1ff, 9'h1ff, 9'h0ff, 9'd127};
    logic [8:0] gv [6] = '{9'd180, 9'h1ff, 9'd181, 9'h1ff, 9'd181, 9'd90};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, MISC_CONTROL_OFS, {24'h0, MISC_CONTROL_RST[7:2], gu[i][8], gv[i][8]}, 4'hf);
      apb(1'b1, U_GAIN_LOW_BYTE_OFS, {24'h0, gu[i][7:0]}, 4'hf); // first and last keep reset ratio
      apb(1'b1, V_GAIN_LOW_BYTE_OFS, {24'h0, gv[i][7:0]}, 4'hf);
      rdc(GAIN_VIEW_OFS, {7'h0, gv[i], 7'h0, gu[i]}, "gain view");
      smp(su[i], su[i], 12'h0);
      cmp({24'h0, out_u}, eg(su[i], gu[i], U_UNITY), "u gain");
      cmp({24'h0, out_v}, eg(su[i], gv[i], V_UNITY), "v gain");
    end
    // Both paths clipped above; clear only the U flag
    rdc(CLIP_STATUS_OFS, (32'h1 << U_CLIP_POS) | (32'h1 << V_CLIP_POS), "clip flags");
    apb(1'b1, CLIP_STATUS_OFS, 32'h1 << U_CLIP_POS, 4'hf);
    rdc(CLIP_STATUS_OFS, 32'h1 << V_CLIP_POS, "clip clear");
    $display("gain test done");
  endtask
  task automatic t_hue();
    logic [7:0] hc [4] = '{8'h80, 8'h7f, 8'h01, 8'hff};
    logic [11:0] ex;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, DECODE_MODE_OFS, m, 4'hf);
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, HUE_PHASE_OFFSET_OFS, {24'h0, hc[i]}, 4'hf);
        rdc(HUE_PHASE_OFFSET_OFS, {24'h0, hc[i]}, "hue back");
        ex = (m == 0) ? 12'h400 + ({{4{hc[i][7]}}, hc[i]} << 3) : 12'h400;
        smp(8'd0, 8'd0, 12'h400);
        cmp({20'h0, out_phase}, {20'h0, ex}, "hue phase");
      end
    end
    $display("hue test done");
  endtask
  // Reset in mid-run must restore the hue, gain low byte and clip status registers
  task automatic t_rst_mid();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(HUE_PHASE_OFFSET_OFS, {24'h0, HUE_PHASE_OFFSET_RST}, "hue after reset");
    rdc(U_GAIN_LOW_BYTE_OFS, {24'h0, U_GAIN_LOW_BYTE_RST}, "u low after reset");
    rdc(V_GAIN_LOW_BYTE_OFS, {24'h0, V_GAIN_LOW_BYTE_RST}, "v low after reset");
    rdc(CLIP_STATUS_OFS, 32'h0, "clip after reset");
    smp(8'd20, 8'd20, 12'h200);
    cmp({20'h0, out_phase}, 32'h200, "phase after reset");
    cmp({24'h0, out_u}, 32'h14, "u after reset");
    $display("mid reset test done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_err();
    t_gain();
    t_hue();
    t_rst_mid();
    complete_run();
  end
endmodule // csh_chroma_adjust_tb_top
